/* File: verilog/rlt_reload_timer.sv */
/*
 * 8-bit up-counting timer with interval and auto-reload modes, an
 * external event source, and an APB register slave.
 * Assumes a 20 MHz ref_clk, synchronous active-high srst, and a power
 * controller that drives power_state.
 */
// Notes on behaviour
// - mode bit 7 chooses interval (0) or auto-reload (1) counting.
// - mode bits 6..3 read as one and ignore writes.
// - count source code picks a prescaler tap or external event edges.
// - event edge direction follows the edge select bit.
// - counter increments once per selected tick, readable anytime.
// - every overflow past FF sets the overflow request flag.
// - interrupt only while overflow interrupt enable is one.
// - count address reads counter, writes go to reload register.
// - reload write also loads the counter immediately in either mode.
// - interval mode wraps FF to 00 and keeps counting.
// - auto-reload mode loads the reload value on each overflow.
// - auto-reload shares sources, flag and interrupt with interval mode.
// - reset gives mode 78, counter and reload 00, interval mode.
// - counter runs in active and sleep only; mode always retained.
`timescale 1ns/1ps
`include "rlt_consts.svh"

module rlt_reload_timer
    import rlt_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        event_input_pin,
    input  wire rlt_pwr_t    power_state,
    output logic             irq
);

    // =================================================================
    // state and next values
    logic      auto_reload_select_reg;
    logic      auto_reload_select_next;
    logic [2:0] count_source_select_reg;
    logic [2:0] count_source_select_next;
    rlt_byte_t count_value_reg;
    rlt_byte_t count_value_next;
    rlt_byte_t reload_value_reg;
    rlt_byte_t reload_value_next;
    logic      overflow_request_flag_reg;
    logic      overflow_request_flag_next;
    logic      overflow_irq_enable_reg;
    logic      overflow_irq_enable_next;
    logic      event_edge_select_reg;
    logic      event_edge_select_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    logic [6:0] ps_tick;
    logic       event_pulse;
    logic       run;
    logic       src_tick;
    logic       overflow;
    logic       setup_rd;
    logic       access_wr;
    logic       mapped;
    logic       wr_count;

    // mode reset value as a typed constant so its fields can be selected
    localparam rlt_byte_t mode_reset = `RLT_MODE_RST;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    // address decode: byte address is four times the index
    function automatic logic reg_hit(input logic [31:0] a, input logic [15:0] idx);
        return a == {14'h0, idx, 2'h0};
    endfunction

    // =================================================================
    // submodules
    rlt_prescaler u_prescaler (
        .ref_clk (ref_clk),
        .srst    (srst),
        .tick    (ps_tick)
    );

    rlt_event_sync u_event_sync (
        .ref_clk           (ref_clk),
        .srst              (srst),
        .event_input_pin   (event_input_pin),
        .event_edge_select (event_edge_select_reg),
        .event_pulse       (event_pulse)
    );

    // =================================================================
    // bus decode; the slave always answers without wait states
    assign mapped    = reg_hit(paddr, `RLT_IDX_MODE) | reg_hit(paddr, `RLT_IDX_COUNT)
                     | reg_hit(paddr, `RLT_IDX_STAT) | reg_hit(paddr, `RLT_IDX_CLR)
                     | reg_hit(paddr, `RLT_IDX_IEN)  | reg_hit(paddr, `RLT_IDX_EDGE);
    assign setup_rd  = psel & ~penable & ~pwrite;
    assign access_wr = psel & penable & pwrite;
    assign wr_count  = access_wr & reg_hit(paddr, `RLT_IDX_COUNT);
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~mapped;
    assign prdata    = prdata_reg;

    // counting source and power gating
    assign run = (power_state == RLT_PWR_ACTIVE) | (power_state == RLT_PWR_SLEEP);
    assign src_tick = (count_source_select_reg == `RLT_SEL_EXT) ? event_pulse
                                                                : ps_tick[count_source_select_reg];
    // a reload write in the same cycle wins over the tick
    assign overflow = run & src_tick & (count_value_reg == `RLT_CNT_MAX) & ~wr_count;

    // =================================================================
    // register file and counter next values
    always_comb
    begin
        auto_reload_select_next  = auto_reload_select_reg;
        count_source_select_next = count_source_select_reg;
        count_value_next         = count_value_reg;
        reload_value_next        = reload_value_reg;
        overflow_irq_enable_next = overflow_irq_enable_reg;
        event_edge_select_next   = event_edge_select_reg;
        prdata_next              = prdata_reg;

        // mode register: reserved bits never stored
        if (access_wr && reg_hit(paddr, `RLT_IDX_MODE))
        begin
            auto_reload_select_next  = pwdata[`RLT_AUTO_BIT];
            count_source_select_next = pwdata[`RLT_SEL_HI:0];
        end
        if (access_wr && reg_hit(paddr, `RLT_IDX_IEN))
            overflow_irq_enable_next = pwdata[`RLT_FLAG_BIT];
        if (access_wr && reg_hit(paddr, `RLT_IDX_EDGE))
            event_edge_select_next = pwdata[`RLT_FLAG_BIT];

        // counter
        if (wr_count)
        begin
            reload_value_next = pwdata[7:0];
            count_value_next  = pwdata[7:0];
        end
        else if (overflow)
        begin
            if (auto_reload_select_reg)
                count_value_next = reload_value_reg;
            else
                count_value_next = `RLT_CNT_RST;
        end
        else if (run && src_tick)
            count_value_next = count_value_reg + `RLT_CNT_ONE;

        // read data captured in the setup phase
        if (setup_rd)
        begin
            prdata_next = 32'h0000_0000;
            case (1'b1)
                reg_hit(paddr, `RLT_IDX_MODE):
                    prdata_next[7:0] = {auto_reload_select_reg, `RLT_MODE_RSVD,
                                        count_source_select_reg};
                reg_hit(paddr, `RLT_IDX_COUNT):
                    prdata_next[7:0] = count_value_reg;
                reg_hit(paddr, `RLT_IDX_STAT):
                    prdata_next[`RLT_FLAG_BIT] = overflow_request_flag_reg;
                reg_hit(paddr, `RLT_IDX_IEN):
                    prdata_next[`RLT_FLAG_BIT] = overflow_irq_enable_reg;
                reg_hit(paddr, `RLT_IDX_EDGE):
                    prdata_next[`RLT_FLAG_BIT] = event_edge_select_reg;
                default:
                    prdata_next = 32'h0000_0000;
            endcase
        end
    end

    // =================================================================
    // overflow flag: a new overflow wins over a clear in the same cycle
    always_comb
    begin
        overflow_request_flag_next = overflow_request_flag_reg;
        if (access_wr && reg_hit(paddr, `RLT_IDX_CLR) && pwdata[`RLT_FLAG_BIT])
            overflow_request_flag_next = 1'b0;
        if (overflow)
            overflow_request_flag_next = 1'b1;
    end

    assign irq = overflow_request_flag_reg & overflow_irq_enable_reg;

    // =================================================================
    // state registers
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            auto_reload_select_reg    <= mode_reset[`RLT_AUTO_BIT];
            count_source_select_reg   <= mode_reset[`RLT_SEL_HI:0];
            count_value_reg           <= `RLT_CNT_RST;
            reload_value_reg          <= `RLT_CNT_RST;
            overflow_request_flag_reg <= 1'b0;
            overflow_irq_enable_reg   <= 1'b0;
            event_edge_select_reg     <= 1'b0;
            prdata_reg                <= 32'h0000_0000;
        end
        else
        begin
            auto_reload_select_reg    <= auto_reload_select_next;
            count_source_select_reg   <= count_source_select_next;
            count_value_reg           <= count_value_next;
            reload_value_reg          <= reload_value_next;
            overflow_request_flag_reg <= overflow_request_flag_next;
            overflow_irq_enable_reg   <= overflow_irq_enable_next;
            event_edge_select_reg     <= event_edge_select_next;
            prdata_reg                <= prdata_next;
        end
    end

    // =================================================================
    // checks
    mode_reserved_a : assert property (
        setup_rd && reg_hit(paddr, `RLT_IDX_MODE) |=> prdata[6:3] == `RLT_MODE_RSVD)
        else $error("reserved mode bits not read as one");

    count_inc_a : assert property (
        run && src_tick && !wr_count && count_value_reg != `RLT_CNT_MAX
        |=> count_value_reg == $past(count_value_reg) + `RLT_CNT_ONE)
        else $error("counter did not step by one");

    interval_wrap_a : assert property (
        overflow && !auto_reload_select_reg |=> count_value_reg == `RLT_CNT_RST)
        else $error("interval overflow did not wrap to zero");

    auto_reload_a : assert property (
        overflow && auto_reload_select_reg |=> count_value_reg == $past(reload_value_reg))
        else $error("auto-reload did not load reload value");

    flag_set_a : assert property (
        overflow |=> overflow_request_flag_reg)
        else $error("overflow flag not set");

    irq_gate_a : assert property (
        overflow && overflow_irq_enable_reg && !(access_wr && reg_hit(paddr, `RLT_IDX_IEN))
        |=> irq ##0 overflow_request_flag_reg)
        else $error("enabled overflow raised no interrupt");

    irq_masked_a : assert property (
        !overflow_irq_enable_reg |-> !irq)
        else $error("interrupt while disabled");

    reload_copy_a : assert property (
        wr_count |=> count_value_reg == $past(pwdata[7:0])
                     && reload_value_reg == $past(pwdata[7:0]))
        else $error("reload write not copied to counter");

    halt_lowpower_a : assert property (
        !run && !wr_count |=> $stable(count_value_reg))
        else $error("counter moved in low-power state");

    ext_source_a : assert property (
        count_source_select_reg == `RLT_SEL_EXT && !event_pulse && !wr_count
        |=> $stable(count_value_reg))
        else $error("external source counted without an edge");

    reset_value_a : assert property (@(posedge ref_clk) disable iff (1'b0)
        srst |=> count_value_reg == `RLT_CNT_RST && !auto_reload_select_reg
                 && count_source_select_reg == 3'h0)
        else $error("reset values wrong");

endmodule // rlt_reload_timer

/* File: verilog/rlt_consts.svh */
/*
 * Constants of the 8-bit reload timer: register indices, reset values,
 * field positions and prescaler tap widths.
 * Assumes it is included by bare name wherever a value is needed.
 */
`ifndef RLT_CONSTS_SVH
`define RLT_CONSTS_SVH

// =====================================================================
// register indices (byte address is four times the index)
`define RLT_IDX_MODE    16'hFFB2
`define RLT_IDX_COUNT   16'hFFB3
`define RLT_IDX_STAT    16'hFFB4
`define RLT_IDX_CLR     16'hFFB5
`define RLT_IDX_IEN     16'hFFB6
`define RLT_IDX_EDGE    16'hFFB7

// =====================================================================
// reset values and field layout
`define RLT_MODE_RST    8'h78
`define RLT_CNT_RST     8'h00
`define RLT_BYTE_ZERO   8'h00
`define RLT_CNT_MAX     8'hFF
`define RLT_CNT_ONE     8'h01
`define RLT_MODE_RSVD   4'hF
`define RLT_AUTO_BIT    7
`define RLT_SEL_HI      2
`define RLT_SEL_EXT     3'h7
`define RLT_FLAG_BIT    0

// =====================================================================
// prescaler: counter width and tap widths (divide by two to the width)
`define RLT_PS_W        13
`define RLT_TAP_8192    13
`define RLT_TAP_2048    11
`define RLT_TAP_512     9
`define RLT_TAP_256     8
`define RLT_TAP_64      6
`define RLT_TAP_16      4
`define RLT_TAP_4       2
`define RLT_PS_ONE      13'h0001

`endif

/* File: verilog/rlt_pkg.sv */
/*
 * Types shared by the reload timer modules.
 * Assumes the power controller drives one of the listed states.
 */
package rlt_pkg;

    // =================================================================
    // chip power states seen by the counter
    typedef enum logic [2:0] {
        RLT_PWR_ACTIVE    = 3'h0,
        RLT_PWR_SLEEP     = 3'h1,
        RLT_PWR_WATCH     = 3'h3,
        RLT_PWR_SUBACTIVE = 3'h2,
        RLT_PWR_SUBSLEEP  = 3'h6,
        RLT_PWR_STANDBY   = 3'h7
    } rlt_pwr_t;

    typedef logic [7:0] rlt_byte_t;

endpackage

/* File: verilog/rlt_prescaler.sv */
/*
 * Free-running system clock prescaler with seven divided tick outputs.
 * Assumes one clock, synchronous active-high reset.
 */
`timescale 1ns/1ps
`include "rlt_consts.svh"

module rlt_prescaler
    import rlt_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       srst,
    output logic      [6:0] tick
);

    logic [`RLT_PS_W-1:0] ps_reg;
    logic [`RLT_PS_W-1:0] ps_next;

    // true when the low w bits are all ones
    function automatic logic low_ones(input logic [`RLT_PS_W-1:0] v, input int w);
        logic r;
        r = 1'b1;
        for (int i = 0; i < `RLT_PS_W; i++)
        begin
            if (i < w)
                r = r & v[i];
        end
        return r;
    endfunction

    // =================================================================
    // counter next value
    always_comb
    begin
        ps_next = ps_reg + `RLT_PS_ONE;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            ps_reg <= '0;
        else
            ps_reg <= ps_next;
    end

    // taps ordered by count source code 000..110
    assign tick[0] = low_ones(ps_reg, `RLT_TAP_8192);
    assign tick[1] = low_ones(ps_reg, `RLT_TAP_2048);
    assign tick[2] = low_ones(ps_reg, `RLT_TAP_512);
    assign tick[3] = low_ones(ps_reg, `RLT_TAP_256);
    assign tick[4] = low_ones(ps_reg, `RLT_TAP_64);
    assign tick[5] = low_ones(ps_reg, `RLT_TAP_16);
    assign tick[6] = low_ones(ps_reg, `RLT_TAP_4);

    // divide-by-four tap fires every fourth cycle
    tap_period_a : assert property (@(posedge ref_clk) disable iff (srst)
        tick[6] |=> !tick[6] ##1 !tick[6] ##1 !tick[6] ##1 tick[6])
        else $error("divide-by-four tap period wrong");

endmodule // rlt_prescaler

/* File: verilog/rlt_event_sync.sv */
/*
 * Event pin synchroniser and edge detector.
 * Assumes the pin is asynchronous to ref_clk.
 */
`timescale 1ns/1ps

module rlt_event_sync
    import rlt_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic event_input_pin,
    input  wire logic event_edge_select,
    output logic      event_pulse
);

    logic [2:0] sync_reg;
    logic [2:0] sync_next;
    logic       level_reg;
    logic       level_next;
    logic       agree;

    // a change counts only once stages two and three agree
    assign agree = (sync_reg[1] == sync_reg[2]);

    // =================================================================
    // three-stage shift and filtered pin level
    always_comb
    begin
        sync_next  = {sync_reg[1:0], event_input_pin};
        level_next = agree ? sync_reg[2] : level_reg;
    end

    // reset level matches the idle-low pin, so no false edge follows reset
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            sync_reg  <= 3'h0;
            level_reg <= 1'b0;
        end
        else
        begin
            sync_reg  <= sync_next;
            level_reg <= level_next;
        end
    end

    // one pulse per qualifying edge; high selects rising
    assign event_pulse = agree & (sync_reg[2] != level_reg)
                       & (sync_reg[2] == event_edge_select);

    edge_dir_a : assert property (@(posedge ref_clk) disable iff (srst)
        event_pulse |-> (level_reg != event_edge_select))
        else $error("event pulse on wrong edge");

    single_pulse_a : assert property (@(posedge ref_clk) disable iff (srst)
        event_pulse |=> !event_pulse)
        else $error("event edge counted twice");

endmodule // rlt_event_sync

/* File: verification/rlt_event_src.sv */
/*
 * Event source model: drives the timer's event input pin.
 * Assumes the bench calls pulse from its main sequence.
 */
`timescale 1ns/1ps

module rlt_event_src
(
    input  wire logic ref_clk,
    output logic      pin
);
    // =================================================================
    // idle low until the first pulse
    initial pin = 1'b0;

    // high held four clocks, low five between pulses, wider than the sync chain
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            pin <= 1'b1;
            repeat (4) @(posedge ref_clk);
            pin <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask
endmodule // rlt_event_src

/* File: verification/rlt_reload_timer_tb_top.sv */
/*
 * Self-checking bench for the reload timer: APB master, event source.
 * Assumes the timer answers with zero wait states and bit0 flag registers.
 */
`timescale 1ns/1ps

module rlt_reload_timer_tb_top
    import rlt_pkg::*;
;
    typedef struct packed {
        logic [31:0] a;
        logic        w;
        logic [7:0]  d;
        logic        x;
    } rlt_tb_row_t;

    localparam logic [31:0] MODE = 32'h0003FEC8;
    localparam logic [31:0] CNT  = 32'h0003FECC;
    localparam logic [31:0] STAT = 32'h0003FED0;
    localparam logic [31:0] CLR  = 32'h0003FED4;
    localparam logic [31:0] IEN  = 32'h0003FED8;
    localparam logic [31:0] EDGE = 32'h0003FEDC;
    localparam logic [31:0] BAD  = 32'h0003FEE0;

    logic        ref_clk;
    logic        srst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        event_input_pin;
    rlt_pwr_t    power_state;
    logic        irq;
    logic [7:0]  q;
    logic        e;
    int          fail_count;
    int          total_checks;
    int          cycles;

    // rows: address, write, data, expected error; reads expect data
    rlt_tb_row_t rows [10] = '{
        '{MODE, 1'b1, 8'h07, 1'b0}, '{MODE, 1'b0, 8'h7F, 1'b0},
        '{MODE, 1'b1, 8'h87, 1'b0}, '{MODE, 1'b0, 8'hFF, 1'b0},
        '{CNT,  1'b1, 8'h5A, 1'b0}, '{CNT,  1'b0, 8'h5A, 1'b0},
        '{STAT, 1'b1, 8'h01, 1'b0}, '{STAT, 1'b0, 8'h00, 1'b0},
        '{CLR,  1'b0, 8'h00, 1'b0}, '{BAD,  1'b0, 8'h00, 1'b1}};
    int       div [7] = '{8192, 2048, 512, 256, 64, 16, 4};
    rlt_pwr_t ps [6] = '{RLT_PWR_ACTIVE, RLT_PWR_SLEEP, RLT_PWR_WATCH,
                         RLT_PWR_SUBACTIVE, RLT_PWR_SUBSLEEP, RLT_PWR_STANDBY};

    rlt_reload_timer uut (.ref_clk(ref_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .event_input_pin(event_input_pin), .power_state(power_state), .irq(irq));

    rlt_event_src src (.ref_clk(ref_clk), .pin(event_input_pin));

    // =================================================================
    // clock and hang guard
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            fail_count++;
            $display("ERROR %0t: timeout", $time);
            results();
        end
    end

    // =================================================================
    // bus cycle, comparisons, verdict
    task automatic apb(input logic [31:0] a, input logic w, input logic [7:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        // wait for the slave; only the hang guard ends a stuck wait
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] lo, input logic [7:0] hi);
        total_checks++;
        if (!(g >= lo && g <= hi) || $isunknown(g))
        begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h..%h", $time, g, lo, hi);
        end
    endtask

    task automatic rd(input logic [31:0] a, input logic [7:0] x);
        apb(a, 1'b0, 8'h00);
        chk(q, x, x);
    endtask

    task automatic irq_is(input logic x);
        @(negedge ref_clk);
        chk({7'h00, irq}, {7'h00, x}, {7'h00, x});
    endtask

    task automatic results();
        if (fail_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // =================================================================
    // main sequence
    initial
    begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        power_state = RLT_PWR_ACTIVE;
        fail_count = 0;
        total_checks = 0;
        cycles = 0;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        rd(MODE, 8'h78);
        rd(CNT, 8'h00);
        irq_is(1'b0);
        // table of plain register accesses, counter frozen on event source
        foreach (rows[i])
        begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            chk({7'h00, e}, {7'h00, rows[i].x}, {7'h00, rows[i].x});
            if (!rows[i].w)
                chk(q, rows[i].d, rows[i].d);
        end
        apb(BAD, 1'b1, 8'h55);
        chk({7'h00, e}, 8'h01, 8'h01);
        // event counting, rising edges, interval wrap
        apb(MODE, 1'b1, 8'h07);
        apb(EDGE, 1'b1, 8'h01);
        apb(CNT, 1'b1, 8'hFD);
        src.pulse(2);
        rd(CNT, 8'hFF);
        rd(STAT, 8'h00);
        src.pulse(1);
        repeat (4) @(posedge ref_clk);
        rd(CNT, 8'h00);
        rd(STAT, 8'h01);
        irq_is(1'b0);
        apb(IEN, 1'b1, 8'h01);
        irq_is(1'b1);
        apb(CLR, 1'b1, 8'h01);
        rd(STAT, 8'h00);
        irq_is(1'b0);
        // auto-reload on falling edges, interrupt then masked
        apb(EDGE, 1'b1, 8'h00);
        apb(MODE, 1'b1, 8'h87);
        apb(CNT, 1'b1, 8'hFE);
        src.pulse(2);
        repeat (4) @(posedge ref_clk);
        rd(CNT, 8'hFE);
        rd(STAT, 8'h01);
        irq_is(1'b1);
        apb(IEN, 1'b1, 8'h00);
        irq_is(1'b0);
        apb(CLR, 1'b1, 8'h01);
        // every internal tap: four periods give four or five counts
        foreach (div[i])
        begin
            apb(MODE, 1'b1, i[7:0]);
            apb(CNT, 1'b1, 8'h00);
            repeat (4 * div[i]) @(posedge ref_clk);
            apb(CNT, 1'b0, 8'h00);
            chk(q, 8'h04, 8'h05);
        end
        // power states: runs in active and sleep, halts elsewhere
        foreach (ps[i])
        begin
            power_state <= ps[i];
            apb(CNT, 1'b1, 8'h10);
            repeat (20) @(posedge ref_clk);
            apb(CNT, 1'b0, 8'h00);
            if (i < 2)
                chk(q, 8'h15, 8'h16);
            else
                chk(q, 8'h10, 8'h10);
            rd(MODE, 8'h7E);
        end
        // reset in mid-run restores defaults
        apb(IEN, 1'b1, 8'h01);
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        power_state <= RLT_PWR_ACTIVE;
        rd(MODE, 8'h78);
        rd(CNT, 8'h00);
        rd(IEN, 8'h00);
        rd(STAT, 8'h00);
        irq_is(1'b0);
        results();
    end
endmodule // rlt_reload_timer_tb_top
